// ===== hw/eeprom_dev.sv
// device end: write path of a 256 byte serial eeprom on an spi link
// assumes link pins are asynchronous to CLK_IN and are sampled twice
`timescale 1ns/1ps
module eeprom_dev
    import eeprom_pkg::*;
#(
    parameter int unsigned WC_CYCLES = WC_CYCLES_DEF
)(
    // clock and reset
    input  wire logic       CLK_IN,
    input  wire logic       RST_IN,
    // serial link
    spi_link_if.dev         LINK,
    // device state for the user
    output logic            BUSY_OUT,
    output logic            LATCH_OUT,
    output logic [1:0]      PROTECT_OUT,
    output logic            COMMIT_OUT
);
    localparam int CW = $clog2(WC_CYCLES + 1);

    // ******************************************************
    // input synchronisers
    // ******************************************************
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic       sck_d_ff;
    logic       cs_d_ff;
    wire  [3:0] pins_raw = {LINK.cs_n, LINK.sck, LINK.mosi, LINK.hold_n};
    wire        cs_s     = sync2_ff[3];
    wire        sck_s    = sync2_ff[2];
    wire        mosi_s   = sync2_ff[1];
    wire        hold_s   = sync2_ff[0];

    // two flops per pin, then edge history on the second flop only
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sync1_ff <= 4'hf;
            sync2_ff <= 4'hf;
            sck_d_ff <= 1'b0;
            cs_d_ff  <= 1'b1;
        end else begin
            sync1_ff <= pins_raw;
            sync2_ff <= sync1_ff;
            sck_d_ff <= sck_s;
            cs_d_ff  <= cs_s;
        end
    end

    // ******************************************************
    // frame and bit events
    // ******************************************************
    logic       frame_ff;
    logic [2:0] bit_cnt_ff;
    logic [2:0] byte_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] opcode_ff;
    logic       op_ok_ff;
    wire cs_fall   = cs_d_ff & ~cs_s;
    wire cs_rise   = frame_ff & cs_s;
    // a held pause masks clock edges but keeps every counter intact
    wire run       = frame_ff & ~cs_s & hold_s;
    wire rise_ev   = run & sck_s & ~sck_d_ff;
    wire fall_ev   = run & ~sck_s & sck_d_ff;
    wire byte_done = rise_ev & (bit_cnt_ff == BIT_LAST);
    wire [7:0] byte_in = {shift_ff[6:0], mosi_s};
    wire is_op     = byte_cnt_ff == IDX_OPCODE;
    wire is_addr   = byte_cnt_ff == IDX_ADDRESS;

    // ******************************************************
    // write cycle state
    // ******************************************************
    logic          busy_ff;
    logic          wel_ff;
    logic [1:0]    prot_ff;
    logic [CW-1:0] wc_cnt_ff;
    logic          kind_arr_ff;
    logic [7:0]    addr_ff;
    logic [PAGE_BITS-1:0] wofs_ff;
    logic [PAGE_BYTES-1:0] pvalid_ff;
    logic [7:0]    page_ff [PAGE_BYTES];
    logic [1:0]    stat_new_ff;
    logic [7:0]    tx_ff;
    logic          miso_ff;
    logic          oe_ff;
    logic          commit_ff;
    logic [7:0]    mem [ARRAY_WORDS];

    // only write opcodes taken with the latch already set qualify
    wire wr_op    = (byte_in == OP_ARRAY_WR) | (byte_in == OP_STAT_WR);
    wire nxt_op_ok = wel_ff & ~busy_ff & wr_op;
    wire op_is_wr = op_ok_ff & (opcode_ff == OP_ARRAY_WR);
    wire op_is_sr = op_ok_ff & (opcode_ff == OP_STAT_WR);
    wire rd_arr   = ~busy_ff & (opcode_ff == OP_ARRAY_RD);
    // the opcode register only updates at this byte's end, so look at the byte itself
    wire rd_stat  = (is_op ? byte_in : opcode_ff) == OP_STAT_RD;
    wire on_bound = bit_cnt_ff == 3'h0;

    // protection ranges; pages never straddle a range limit
    wire blocked = (prot_ff == PROT_ALL)
                 | ((prot_ff == PROT_HALF) & (addr_ff >= HALF_BASE))
                 | ((prot_ff == PROT_QUARTER) & (addr_ff >= QUARTER_BASE));

    // a start needs a whole data byte and select rising on its boundary
    wire wr_go = cs_rise & op_is_wr & on_bound
               & (byte_cnt_ff >= WR_MIN_BYTES) & ~blocked;
    wire sr_go = cs_rise & op_is_sr & on_bound
               & (byte_cnt_ff == SR_BYTES);
    wire wc_end = busy_ff & (wc_cnt_ff == '0);

    // status byte: upper bits read high while a write is under way
    wire [3:0] stat_hi  = busy_ff ? STAT_BUSY_HIGH : STAT_IDLE_HIGH;
    wire [7:0] stat_byte = {stat_hi, prot_ff, wel_ff, busy_ff};

    // next transmit byte, chosen when a byte completes
    wire [7:0] arr_addr = is_addr ? byte_in : addr_ff;
    wire [7:0] nxt_tx = rd_stat ? stat_byte
                      : (rd_arr & ~is_op) ? mem[arr_addr] : 8'h00;

    // ******************************************************
    // frame tracking and shifting
    // ******************************************************
    // frames open only on a select fall; a select held low through reset reads as a fall and opens one
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            frame_ff    <= 1'b0;
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 3'h0;
            shift_ff    <= 8'h00;
            opcode_ff   <= 8'h00;
            op_ok_ff    <= 1'b0;
        end else if (cs_fall) begin
            frame_ff    <= 1'b1;
            bit_cnt_ff  <= 3'h0;
            byte_cnt_ff <= 3'h0;
            op_ok_ff    <= 1'b0;
        end else if (cs_rise) begin
            frame_ff    <= 1'b0;
            op_ok_ff    <= 1'b0;
        end else if (rise_ev) begin
            shift_ff   <= byte_in;
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (byte_done && byte_cnt_ff != BYTE_SAT) begin
                byte_cnt_ff <= byte_cnt_ff + 3'h1;
            end
            if (byte_done && is_op) begin
                opcode_ff <= byte_in;
                op_ok_ff  <= nxt_op_ok;
            end
        end
    end

    // ******************************************************
    // latch, protection level, page buffer and write timer
    // ******************************************************
    // latch set needs its own frame: any later byte in it is no opcode
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wel_ff      <= 1'b0;
            busy_ff     <= 1'b0;
            prot_ff     <= PROT_NONE;
            wc_cnt_ff   <= '0;
            kind_arr_ff <= 1'b0;
            addr_ff     <= 8'h00;
            wofs_ff     <= '0;
            pvalid_ff   <= '0;
            stat_new_ff <= PROT_NONE;
            commit_ff   <= 1'b0;
        end else begin
            commit_ff <= wc_end;
            if (byte_done && is_op && !busy_ff) begin
                if (byte_in == OP_SET_LATCH) begin
                    wel_ff <= 1'b1;
                end else if (byte_in == OP_CLR_LATCH) begin
                    wel_ff <= 1'b0;
                end
            end
            // a status poll during a write cycle must not disturb the pending page
            if (byte_done && is_addr && !busy_ff) begin
                addr_ff   <= op_is_sr ? addr_ff : byte_in;
                wofs_ff   <= byte_in[PAGE_BITS-1:0];
                pvalid_ff <= '0;
                if (op_is_sr) begin
                    stat_new_ff <= byte_in[STAT_PROT_MSB:STAT_PROT_LSB];
                end
            end else if (byte_done && rd_arr && !is_op) begin
                addr_ff <= addr_ff + 8'h01;
            end
            if (byte_done && !is_op && !is_addr && op_is_wr) begin
                pvalid_ff[wofs_ff] <= 1'b1;
                wofs_ff <= wofs_ff + 1'b1;
            end
            if (byte_done && is_addr && rd_arr) begin
                addr_ff <= byte_in + 8'h01;
            end
            if (wr_go || sr_go) begin
                busy_ff     <= 1'b1;
                kind_arr_ff <= wr_go;
                wc_cnt_ff   <= CW'(WC_CYCLES - 1);
            end else if (wc_end) begin
                busy_ff <= 1'b0;
                wel_ff  <= 1'b0;
                if (!kind_arr_ff) begin
                    prot_ff <= stat_new_ff;
                end
            end else if (busy_ff) begin
                wc_cnt_ff <= wc_cnt_ff - 1'b1;
            end
        end
    end

    // page data is captured at its offset; the array only at commit
    always_ff @(posedge CLK_IN) begin
        if (byte_done && !is_op && !is_addr && op_is_wr) begin
            page_ff[wofs_ff] <= byte_in;
        end
        if (wc_end && kind_arr_ff) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pvalid_ff[i]) begin
                    mem[{addr_ff[7:PAGE_BITS], PAGE_BITS'(i)}] <= page_ff[i];
                end
            end
        end
    end

    // ******************************************************
    // serial output
    // ******************************************************
    // bits leave on falling edges so the host samples a settled level
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            tx_ff   <= 8'h00;
            miso_ff <= 1'b0;
            oe_ff   <= 1'b0;
        end else begin
            oe_ff <= run;
            if (byte_done) begin
                tx_ff <= nxt_tx;
            end else if (fall_ev) begin
                miso_ff <= tx_ff[7];
                tx_ff   <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    assign LINK.miso    = miso_ff;
    assign LINK.miso_oe = oe_ff;
    assign BUSY_OUT     = busy_ff;
    assign LATCH_OUT    = wel_ff;
    assign PROTECT_OUT  = prot_ff;
    assign COMMIT_OUT   = commit_ff;
endmodule : eeprom_dev

// ===== hw/eeprom_host.sv
// host end: spi master driven from an avalon-mm register slave
// assumes the device end samples the link with its own clock
`timescale 1ns/1ps
module eeprom_host
    import eeprom_pkg::*;
#(
    parameter int unsigned PUW_CYCLES = PUW_CYCLES_DEF,
    parameter int unsigned SCK_HALF   = SCK_HALF_DEF
)(
    // clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_IN,
    // avalon-mm slave
    input  wire logic [1:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    output logic [31:0]      AVS_READDATA_OUT,
    output logic             AVS_WAITREQUEST_OUT,
    // serial link
    spi_link_if.host         LINK
);
    localparam int PW = $clog2(PUW_CYCLES + 1);
    localparam int HW = $clog2(SCK_HALF + 1);
    typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_XFER, ST_LAG, ST_GAP} state_t;

    // ******************************************************
    // register slave
    // ******************************************************
    logic        ack_ff;
    logic [31:0] rdata_ff;
    logic [10:0] cmd_ff;
    logic [31:0] data_ff;
    logic [7:0]  addr_ff;
    logic        pause_ff;
    logic [7:0]  rx_ff;
    logic [PW-1:0] pu_cnt_ff;
    state_t      state_ff;
    wire req      = AVS_READ_IN | AVS_WRITE_IN;
    wire wr_take  = AVS_WRITE_IN & ack_ff;
    wire pu_done  = pu_cnt_ff == '0;
    wire busy     = state_ff != ST_IDLE;
    wire start    = wr_take & (AVS_ADDRESS_IN == REG_CMD) & ~busy & pu_done;
    wire [31:0] stat_word = {16'h0000, rx_ff, 6'h00, pu_done, busy};
    wire [31:0] rd_mux = (AVS_ADDRESS_IN == REG_CMD)  ? {21'h000000, cmd_ff}
                       : (AVS_ADDRESS_IN == REG_DATA) ? data_ff
                       : (AVS_ADDRESS_IN == REG_ADDR) ? {24'h000000, addr_ff}
                       : stat_word;

    // one wait cycle per access; read data captured as wait drops
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            ack_ff    <= 1'b0;
            rdata_ff  <= 32'h00000000;
            cmd_ff    <= 11'h000;
            data_ff   <= 32'h00000000;
            addr_ff   <= 8'h00;
            pause_ff  <= 1'b0;
            pu_cnt_ff <= PW'(PUW_CYCLES);
        end else begin
            ack_ff <= req & ~ack_ff;
            if (req && !ack_ff) begin
                rdata_ff <= rd_mux;
            end
            if (!pu_done) begin
                pu_cnt_ff <= pu_cnt_ff - 1'b1;
            end
            if (wr_take && AVS_ADDRESS_IN == REG_DATA) begin
                data_ff <= AVS_WRITEDATA_IN;
            end
            if (wr_take && AVS_ADDRESS_IN == REG_ADDR) begin
                addr_ff <= AVS_WRITEDATA_IN[7:0];
            end
            if (wr_take && AVS_ADDRESS_IN == REG_STATUS) begin
                pause_ff <= AVS_WRITEDATA_IN[0];
            end
            if (start) begin
                cmd_ff <= AVS_WRITEDATA_IN[10:0];
            end
        end
    end

    // ******************************************************
    // serial engine
    // ******************************************************
    logic          miso1_ff;
    logic          miso2_ff;
    logic [HW-1:0] div_ff;
    logic          sck_ff;
    logic          cs_n_ff;
    logic          hold_n_ff;
    logic [47:0]   frame_ff;
    logic [5:0]    bits_ff;
    wire tick = div_ff == '0;
    wire [5:0] nbits = {AVS_WRITEDATA_IN[10:8], 3'h0};

    // select starts high so the first frame shows a clean fall
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            miso1_ff  <= 1'b0;
            miso2_ff  <= 1'b0;
            div_ff    <= '0;
            sck_ff    <= 1'b0;
            cs_n_ff   <= 1'b1;
            hold_n_ff <= 1'b1;
            frame_ff  <= 48'h000000000000;
            bits_ff   <= 6'h00;
            rx_ff     <= 8'h00;
            state_ff  <= ST_IDLE;
        end else begin
            miso1_ff <= LINK.miso;
            miso2_ff <= miso1_ff;
            div_ff   <= tick ? HW'(SCK_HALF - 1) : div_ff - 1'b1;
            if (!sck_ff) begin
                hold_n_ff <= ~pause_ff;
            end
            unique case (state_ff)
                ST_IDLE: begin
                    if (start) begin
                        frame_ff <= {AVS_WRITEDATA_IN[7:0], addr_ff, data_ff[7:0],
                                     data_ff[15:8], data_ff[23:16], data_ff[31:24]};
                        bits_ff  <= nbits;
                        cs_n_ff  <= 1'b0;
                        state_ff <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    if (tick) begin
                        state_ff <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    // no rise once a pause is asked for, so the pause lands with sck low
                    if (tick && !sck_ff && hold_n_ff && !pause_ff) begin
                        sck_ff <= 1'b1;
                    end else if (tick && sck_ff) begin
                        sck_ff   <= 1'b0;
                        rx_ff    <= {rx_ff[6:0], miso2_ff};
                        frame_ff <= {frame_ff[46:0], 1'b0};
                        bits_ff  <= bits_ff - 6'h01;
                        if (bits_ff == 6'h01) begin
                            state_ff <= ST_LAG;
                        end
                    end
                end
                ST_LAG: begin
                    if (tick) begin
                        cs_n_ff  <= 1'b1;
                        state_ff <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (tick) begin
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign AVS_READDATA_OUT    = rdata_ff;
    assign AVS_WAITREQUEST_OUT = ~ack_ff;
    assign LINK.cs_n   = cs_n_ff;
    assign LINK.sck    = sck_ff;
    assign LINK.mosi   = frame_ff[47];
    assign LINK.hold_n = hold_n_ff;
endmodule : eeprom_host

// ===== include/eeprom_pkg.sv
// constants shared by the serial eeprom device end and its spi host end
// assumes a single 250 MHz system clock on both ends
package eeprom_pkg;
    // ******************************************************
    // instruction codes, sent msb first
    // ******************************************************
    localparam logic [7:0] OP_SET_LATCH = 8'h06; // set_write_latch_cmd
    localparam logic [7:0] OP_CLR_LATCH = 8'h04; // clear_write_latch_cmd
    localparam logic [7:0] OP_STAT_RD   = 8'h05; // status_read_cmd
    localparam logic [7:0] OP_STAT_WR   = 8'h01; // status_write_cmd
    localparam logic [7:0] OP_ARRAY_RD  = 8'h03;
    localparam logic [7:0] OP_ARRAY_WR  = 8'h02;
    // ******************************************************
    // status byte layout and protection levels
    // ******************************************************
    localparam int  STAT_BUSY_BIT   = 0;
    localparam int  STAT_LATCH_BIT  = 1;
    localparam int  STAT_PROT_LSB   = 2;
    localparam int  STAT_PROT_MSB   = 3;
    localparam logic [3:0] STAT_BUSY_HIGH = 4'hf;
    localparam logic [3:0] STAT_IDLE_HIGH = 4'h0;
    localparam logic [1:0] PROT_NONE    = 2'h0;
    localparam logic [1:0] PROT_QUARTER = 2'h1;
    localparam logic [1:0] PROT_HALF    = 2'h2;
    localparam logic [1:0] PROT_ALL     = 2'h3;
    localparam logic [7:0] QUARTER_BASE = 8'hc0;
    localparam logic [7:0] HALF_BASE    = 8'h80;
    // ******************************************************
    // array geometry and frame layout
    // ******************************************************
    localparam int  ARRAY_WORDS  = 256;
    localparam int  PAGE_BYTES   = 4;
    localparam int  PAGE_BITS    = 2;
    localparam logic [2:0] IDX_OPCODE   = 3'h0;
    localparam logic [2:0] IDX_ADDRESS  = 3'h1;
    localparam logic [2:0] WR_MIN_BYTES = 3'h3;
    localparam logic [2:0] SR_BYTES     = 3'h2;
    localparam logic [2:0] BYTE_SAT     = 3'h7;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    // ******************************************************
    // timing
    // ******************************************************
    localparam int CLK_MHZ      = 250;
    localparam int T_WRITE_MS   = 10;  // self-timed write cycle
    localparam int T_PWR_WR_MS  = 5;   // power-up to first write
    localparam int WC_CYCLES_DEF  = T_WRITE_MS * CLK_MHZ * 1000;
    localparam int PUW_CYCLES_DEF = T_PWR_WR_MS * CLK_MHZ * 1000;
    localparam int SCK_HALF_DEF   = 6; // 48 ns serial clock period
    // ******************************************************
    // host register map, word addresses
    // ******************************************************
    localparam logic [1:0] REG_CMD    = 2'h0;
    localparam logic [1:0] REG_DATA   = 2'h1;
    localparam logic [1:0] REG_ADDR   = 2'h2;
    localparam logic [1:0] REG_STATUS = 2'h3;
endpackage : eeprom_pkg

// ===== include/spi_link_if.sv
// the serial link between the eeprom device end and its host end
// assumes the bench resolves the output-enabled data line if it wants a wire
`timescale 1ns/1ps
interface spi_link_if;
    logic cs_n;     // select, low active
    logic sck;      // serial clock from host
    logic mosi;     // data into device
    logic hold_n;   // pause, low active
    logic miso;     // data out of device
    logic miso_oe;  // device drives miso
    modport dev  (input cs_n, sck, mosi, hold_n, output miso, miso_oe);
    modport host (output cs_n, sck, mosi, hold_n, input miso, miso_oe);
endinterface : spi_link_if

// ===== verification/eeprom_link_sva.sv
// link checker: watches the spi wires between the two ends
// assumes the host runs its default half period of 6 clocks
`timescale 1ns/1ps
module eeprom_link_sva (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic RST_IN,
    // link wires
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic hold_n,
    input wire logic miso,
    input wire logic miso_oe
);
    logic       sck_ff;
    logic [2:0] bits_ff;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RST_IN);
    // rises of sck per frame, mod 8, so a frame must end on a whole byte
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            sck_ff  <= 1'b0;
            bits_ff <= 3'h0;
        end else begin
            sck_ff  <= sck;
            bits_ff <= cs_n ? 3'h0 : bits_ff + 3'(sck && !sck_ff);
        end
    end
    property p_rst; $fell(RST_IN) |-> cs_n && hold_n && !miso_oe; endproperty
    a_rst: assert property (p_rst) else $error("link not idle after reset");
    property p_off; cs_n [*8] |-> !miso_oe; endproperty
    a_off: assert property (p_off) else $error("miso driven while deselected");
    property p_sel; cs_n |-> !sck; endproperty
    a_sel: assert property (p_sel) else $error("sck moved while deselected");
    property p_mosi; sck && $past(sck) |-> $stable(mosi); endproperty
    a_mosi: assert property (p_mosi) else $error("mosi moved while sck high");
    property p_hold; $changed(hold_n) |-> !sck && !$past(sck); endproperty
    a_hold: assert property (p_hold) else $error("pause moved while sck high");
    property p_pause; !hold_n && !$past(hold_n) |-> $stable(sck); endproperty
    a_pause: assert property (p_pause) else $error("sck ran during pause");
    property p_high; $rose(sck) |-> sck [*6] ##1 !sck; endproperty
    a_high: assert property (p_high) else $error("sck high phase not 6");
    property p_end; $rose(cs_n) |-> !sck && bits_ff == 3'h0; endproperty
    a_end: assert property (p_end) else $error("frame ended off a byte");
    property p_miso; $changed(miso) |-> !sck; endproperty
    a_miso: assert property (p_miso) else $error("miso moved while sck high");
endmodule : eeprom_link_sva

// ===== verification/serial_eeprom_write_sequencer_bench.sv
// bench: host end drives device end over the link; a model checks results
// assumes a shortened write cycle and power-up wait
`timescale 1ns/1ps
module serial_eeprom_write_sequencer_bench
    import eeprom_pkg::*;
;
    logic        clk, rst, rd, wr, waitreq, busy, latch_pin, commit, latch;
    logic [1:0]  adr, prot_pin, prot;
    logic [31:0] wdat, rdat, bq, rv;
    logic [7:0]  mem [256];
    logic [7:0]  last, a, b;
    int          n_errors, compares, commits, ecommits, cyc;
    spi_link_if link ();
    eeprom_dev #(.WC_CYCLES(600)) eeprom_dev_inst (.CLK_IN(clk), .RST_IN(rst), .LINK(link),
        .BUSY_OUT(busy), .LATCH_OUT(latch_pin), .PROTECT_OUT(prot_pin), .COMMIT_OUT(commit));
    eeprom_host #(.PUW_CYCLES(20)) eeprom_host_inst (.CLK_IN(clk), .RST_IN(rst),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdat),
        .AVS_READDATA_OUT(rdat), .AVS_WAITREQUEST_OUT(waitreq), .LINK(link));
    eeprom_link_sva eeprom_link_sva_inst (.CLK_IN(clk), .RST_IN(rst), .cs_n(link.cs_n),
        .sck(link.sck), .mosi(link.mosi), .hold_n(link.hold_n), .miso(link.miso),
        .miso_oe(link.miso_oe));
    // ****
    // tasks
    // ****
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one avalon access: held until waitrequest is seen low
    task automatic bus(logic w, logic [1:0] ad, logic [31:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= ad;
        wdat <= d;
        do @(posedge clk); while (waitreq !== 1'b0);
        bq = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // one frame; the optional pause lands mid-frame
    task automatic cmd(logic [7:0] op, logic [2:0] n, logic [7:0] ad, logic [31:0] d, bit p);
        bus(1'b1, REG_ADDR, {24'h0, ad});
        bus(1'b1, REG_DATA, d);
        bus(1'b1, REG_CMD, {21'h0, n, op});
        if (p) begin
            repeat (90) @(posedge clk);
            bus(1'b1, REG_STATUS, 32'h1);
            repeat (200) @(posedge clk);
            bus(1'b1, REG_STATUS, 32'h0);
        end
        do bus(1'b0, REG_STATUS, 32'h0); while (bq[0] !== 1'b0);
        last = bq[15:8];
    endtask : cmd
    function automatic bit blk(logic [7:0] ad);
        return prot == PROT_ALL || (prot == PROT_HALF && ad >= HALF_BASE)
            || (prot == PROT_QUARTER && ad >= QUARTER_BASE);
    endfunction : blk
    // a refused write keeps the latch: no cycle ever ran to clear it
    task automatic put(logic [7:0] op, logic [7:0] ad, logic [31:0] d, int k, bit en);
        bit go;
        if (en) cmd(OP_SET_LATCH, 3'h1, 8'h0, 32'h0, 1'b0);
        latch = en;
        go = en && (op == OP_STAT_WR || !blk(ad));
        cmd(op, 3'(k + 2), ad, d, 1'b0);
        if (go) begin
            ecommits++;
            for (int i = 0; i < k; i++) mem[{ad[7:2], ad[1:0] + 2'(i)}] = d[8*i+:8];
            cmd(OP_STAT_RD, 3'h2, 8'h0, 32'h0, 1'b0);
            chk("stat_busy", {4'hf, prot, 2'h3}, last);
            chk("busy_pin", 8'h1, 8'(busy));
            while (last[0] === 1'b1) cmd(OP_STAT_RD, 3'h2, 8'h0, 32'h0, 1'b0);
            latch = 1'b0;
            if (op == OP_STAT_WR) prot = ad[3:2];
        end
        cmd(OP_STAT_RD, 3'h2, 8'h0, 32'h0, 1'b0);
        chk("stat_idle", {4'h0, prot, latch, 1'b0}, last);
        chk("prot_pin", 8'(prot), 8'(prot_pin));
    endtask : put
    task automatic look(logic [7:0] ad, bit p);
        cmd(OP_ARRAY_RD, 3'h3, ad, 32'h0, p);
        chk("array", mem[ad], last);
    endtask : look
    // ****
    // clock, watchdog, sequence
    // ****
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (commit === 1'b1) commits <= commits + 1;
        if (cyc == 80000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        adr = 2'h0;
        wdat = 32'h0;
        prot = 2'h0;
        void'($urandom(34));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        chk("reset_pins", 8'h0, {5'h0, link.miso_oe, busy, latch_pin});
        do bus(1'b0, REG_STATUS, 32'h0); while (bq[1] !== 1'b1);
        cmd(OP_SET_LATCH, 3'h1, 8'h0, 32'h0, 1'b0);
        cmd(OP_STAT_RD, 3'h2, 8'h0, 32'h0, 1'b0);
        chk("latch_set", 8'h02, last);
        cmd(OP_CLR_LATCH, 3'h1, 8'h0, 32'h0, 1'b0);
        cmd(OP_STAT_RD, 3'h2, 8'h0, 32'h0, 1'b0);
        chk("latch_clr", 8'h00, last);
        $display("latch test done");
        a = {2'h0, 4'($urandom), 2'h2};
        rv = $urandom;
        put(OP_ARRAY_WR, a, rv, 4, 1'b1);
        put(OP_ARRAY_WR, a, ~rv, 1, 1'b0);
        // latch set, then a whole write in the same frame: must be ignored
        cmd(OP_SET_LATCH, 3'h4, OP_ARRAY_WR, {16'h0, ~mem[a], a}, 1'b0);
        for (int i = 0; i < 4; i++) look({a[7:2], 2'(i)}, i == 0);
        $display("page test done");
        for (int lv = 1; lv < 5; lv++) begin
            put(OP_STAT_WR, {4'h0, 2'(lv), 2'h0}, 32'h0, 0, 1'b1);
            for (int j = 1; j < 4; j++) begin
                b = {2'(j), 6'($urandom)};
                put(OP_ARRAY_WR, b, $urandom, 1, 1'b1);
                look(b, 1'b0);
            end
        end
        $display("protect test done");
        chk("commits", 8'(ecommits), 8'(commits));
        close_out();
    end
endmodule : serial_eeprom_write_sequencer_bench
